// File: common/dacwc_bus_if.sv
// Two-wire bus plus the latch / high-voltage pin between host and DAC.
// Open-drain lines: any enabled driver pulls low, otherwise pulled high.
`timescale 1ns/100ps
interface dacwc_bus_if;
    logic hostSclOe;
    logic hostSclOut;
    logic hostSdaOe;
    logic hostSdaOut;
    logic devSdaOe;
    logic devSdaOut;
    logic latLow;
    logic hvHigh;
    wire logic scl;
    wire logic sda;

    assign scl = ~(hostSclOe & ~hostSclOut);
    assign sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

    modport dev (
        input scl,
        input sda,
        input latLow,
        input hvHigh,
        output devSdaOe,
        output devSdaOut
    );

    modport host (
        input sda,
        output hostSclOe,
        output hostSclOut,
        output hostSdaOe,
        output hostSdaOut,
        output latLow,
        output hvHigh
    );
endinterface : dacwc_bus_if

// File: common/dacwc_pkg.sv
// Shared constants and state types for both ends of the DAC write link.
// Assumes a single 10 MHz core clock on each end.
package dacwc_pkg;
    localparam int CLK_MHZ = 10;
    // Programming cycle time in microseconds and its length in clocks
    localparam int PROG_TIME_US = 5000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    // Extra clocks the host keeps the high-voltage level after the cycle
    localparam int HV_MARGIN_CYC = 64;
    // Core clocks per quarter of a host-made serial clock period
    localparam logic [2:0] HOST_QUARTER = 3'h5;
    localparam logic [6:0] SLAVE_ADDR = 7'h60;
    localparam logic [4:0] ADDR_DAC0 = 5'h00;
    localparam logic [4:0] ADDR_DAC1 = 5'h01;
    localparam logic [4:0] ADDR_V08 = 5'h08;
    localparam logic [4:0] ADDR_V09 = 5'h09;
    localparam logic [4:0] ADDR_V0A = 5'h0a;
    localparam logic [4:0] MTP_BASE = 5'h10;
    localparam logic [1:0] CMD_WRITE = 2'h0;
    localparam logic [1:0] CMD_READ = 2'h3;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] ACK_DRIVE = 4'h9;
    localparam logic [1:0] BYTE_LAST = 2'h3;
    localparam logic [15:0] DAC_RESET = 16'h0000;
    // Sync order: hv, latch, sda, scl; idle bus lines read high
    localparam logic [3:0] SYNC_RESET = 4'h3;

    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_CTRL = 3'h1,
        D_CMD = 3'h3,
        D_DHI = 3'h2,
        D_DLO = 3'h6,
        D_SKIP = 3'h7
    } dacwc_dstate_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_START = 3'h1,
        H_BYTE = 3'h3,
        H_WAIT = 3'h2,
        H_STOP = 3'h6
    } dacwc_hstate_t;
endpackage : dacwc_pkg

// File: dv/dacwc_bus_properties.sv
// Wire-level checks on the bus that joins the host and DAC ends.
// Assumes both ends share core_clk; scl and sda are the resolved lines.
`timescale 1ns/100ps
module dacwc_bus_properties (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Reset, active high
    input wire logic scl, // Resolved serial clock
    input wire logic sda, // Resolved serial data
    input wire logic devSdaOe, // Device pulls sda low
    input wire logic latLow, // Latch pin low
    input wire logic hvHigh // Pin at programming level
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_ack_scl_low: assert property ($changed(devSdaOe) |-> !scl)
        else $error("ACK drive changed while scl high");
    a_ack_bounded: assert property ($rose(devSdaOe) |-> ##[1:40] !devSdaOe)
        else $error("ACK not released in time");
    a_ack_hold: assert property ($rose(scl) && devSdaOe |-> devSdaOe[*8])
        else $error("ACK dropped during scl high");
    a_pin_exclusive: assert property (!(latLow && hvHigh))
        else $error("Latch and programming level together");
    a_scl_high_span: assert property ($rose(scl) |-> scl[*8])
        else $error("Serial clock high phase too short");
    a_scl_low_span: assert property ($fell(scl) |-> !scl[*8])
        else $error("Serial clock low phase too short");
    a_no_false_start: assert property (
        scl && $past(scl) && $fell(sda) |-> !devSdaOe)
        else $error("Device made a Start condition");
    a_stop_idle: assert property (
        scl && $past(scl) && $rose(sda) |-> (scl && sda)[*4])
        else $error("Bus not idle after Stop");
endmodule : dacwc_bus_properties

// File: dv/tb.sv
// Self-checking bench: host end sends write frames to the DAC end.
// Assumes a 10 MHz core clock and a shortened programming cycle.
`timescale 1ns/100ps
`define CHECK(nm, ex, ac) \
    begin \
        testsRun++; \
        if ((ac) !== (ex)) \
        begin \
            failures++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, ac); \
        end \
    end
module tb
    import dacwc_pkg::*;
;
    localparam int PROG = 5000;
    logic core_clk, rst, cmdValid, cmdLast, latchReq, hvReq;
    logic [4:0] cmdAddr, wrAddr;
    logic [15:0] cmdData, dacOut0, dacOut1, wrData;
    logic cmdReady, frameDone, frameNack, hvHold;
    logic wrStrobe, wrNv, mtpBusy, errFlag, nackSeen;
    int failures, testsRun, volCnt, nvCnt, v, n;
    logic errSingle, nackSingle;

    dacwc_bus_if bus ();
    dacwc_dev_end #(.DUAL(1'b1), .PROG_CYC(PROG)) i_dacwc_dev_end (
        .core_clk(core_clk), .rst(rst), .bus(bus.dev),
        .dacOut0(dacOut0), .dacOut1(dacOut1), .wrStrobe(wrStrobe),
        .wrNv(wrNv), .wrAddr(wrAddr), .wrData(wrData),
        .mtpBusy(mtpBusy), .errFlag(errFlag));
    dacwc_host_end #(.HOLD_CYC(PROG + HV_MARGIN_CYC)) i_dacwc_host_end (
        .core_clk(core_clk), .rst(rst), .bus(bus.host),
        .cmdValid(cmdValid), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .cmdLast(cmdLast), .latchReq(latchReq), .hvReq(hvReq),
        .cmdReady(cmdReady), .frameDone(frameDone),
        .frameNack(frameNack), .hvHold(hvHold));
    // Single-channel pair runs in lock step with the dual pair
    dacwc_bus_if busSingle ();
    dacwc_dev_end #(.DUAL(1'b0), .PROG_CYC(PROG)) i_dacwc_dev_end_single (
        .core_clk(core_clk), .rst(rst), .bus(busSingle.dev),
        .dacOut0(), .dacOut1(), .wrStrobe(), .wrNv(), .wrAddr(),
        .wrData(), .mtpBusy(), .errFlag(errSingle));
    dacwc_host_end #(.HOLD_CYC(PROG + HV_MARGIN_CYC)) i_dacwc_host_end_single (
        .core_clk(core_clk), .rst(rst), .bus(busSingle.host),
        .cmdValid(cmdValid), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .cmdLast(cmdLast), .latchReq(latchReq), .hvReq(hvReq),
        .cmdReady(), .frameDone(), .frameNack(nackSingle), .hvHold());
    dacwc_bus_properties i_dacwc_bus_properties (
        .core_clk(core_clk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
        .devSdaOe(bus.devSdaOe), .latLow(bus.latLow), .hvHigh(bus.hvHigh));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Count committed words by memory kind
    always @(posedge core_clk)
    begin
        if (wrStrobe === 1'b1 && wrNv === 1'b1)
            nvCnt++;
        else if (wrStrobe === 1'b1)
            volCnt++;
    end

    task automatic waitc(input int c);
        repeat (c) @(posedge core_clk);
    endtask : waitc

    // Offer one word and hold it until the host takes it
    task automatic word(input logic [4:0] a, input logic [15:0] d,
        input logic l);
        logic got;
        got = 1'b0;
        @(posedge core_clk);
        cmdValid <= 1'b1;
        cmdAddr <= a;
        cmdData <= d;
        cmdLast <= l;
        for (int i = 0; i < 5000; i++)
        begin
            @(posedge core_clk);
            if (cmdReady === 1'b1)
            begin
                got = 1'b1;
                break;
            end
        end
        cmdValid <= 1'b0;
        `CHECK("word taken", 1'b1, got)
    endtask : word

    task automatic frame_end;
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 5000; i++)
        begin
            @(posedge core_clk);
            if (frameDone === 1'b1)
            begin
                seen = 1'b1;
                break;
            end
        end
        `CHECK("frame done", 1'b1, seen)
        nackSeen = frameNack;
        waitc(10);
    endtask : frame_end

    task automatic t_volatile;
        word(ADDR_DAC0, 16'h1234, 1'b1);
        frame_end();
        `CHECK("nack", 1'b0, nackSeen)
        `CHECK("single nack", 1'b0, nackSingle)
        `CHECK("commits", 1, volCnt)
        `CHECK("addr", ADDR_DAC0, wrAddr)
        `CHECK("data", 16'h1234, wrData)
        `CHECK("out held", DAC_RESET, dacOut0)
        latchReq <= 1'b1;
        waitc(10);
        `CHECK("out latched", 16'h1234, dacOut0)
        latchReq <= 1'b0;
    endtask : t_volatile

    task automatic t_continuous;
        v = volCnt;
        word(ADDR_V08, 16'h1111, 1'b0);
        word(ADDR_V09, 16'h2222, 1'b0);
        word(ADDR_V0A, 16'h3333, 1'b0);
        word(ADDR_DAC1, 16'h4444, 1'b1);
        frame_end();
        `CHECK("nack", 1'b0, nackSeen)
        `CHECK("commits", v + 4, volCnt)
        `CHECK("addr", ADDR_DAC1, wrAddr)
        `CHECK("data", 16'h4444, wrData)
        `CHECK("single nack", 1'b1, nackSingle)
        `CHECK("single error", 1'b1, errSingle)
        latchReq <= 1'b1;
        waitc(10);
        `CHECK("out1 latched", 16'h4444, dacOut1)
        latchReq <= 1'b0;
    endtask : t_continuous

    task automatic t_bad_addr;
        v = volCnt;
        word(5'h02, 16'h5a5a, 1'b1);
        frame_end();
        `CHECK("nack", 1'b1, nackSeen)
        `CHECK("error", 1'b1, errFlag)
        `CHECK("commits", v, volCnt)
        word(ADDR_V08, 16'h0f0f, 1'b1);
        frame_end();
        `CHECK("error cleared", 1'b0, errFlag)
        `CHECK("nack", 1'b0, nackSeen)
        `CHECK("data", 16'h0f0f, wrData)
    endtask : t_bad_addr

    task automatic t_nv_no_hv;
        n = nvCnt;
        word(MTP_BASE, 16'hbeef, 1'b1);
        frame_end();
        `CHECK("nack", 1'b0, nackSeen)
        `CHECK("busy", 1'b0, mtpBusy)
        `CHECK("hv idle", 1'b0, hvHold)
        waitc(PROG + 50);
        `CHECK("nv writes", n, nvCnt)
    endtask : t_nv_no_hv

    task automatic t_nv_cont;
        v = volCnt;
        hvReq <= 1'b1;
        waitc(10);
        word(5'h13, 16'hcafe, 1'b0);
        word(ADDR_V09, 16'h7777, 1'b1);
        frame_end();
        `CHECK("nack", 1'b1, nackSeen)
        `CHECK("error", 1'b1, errFlag)
        `CHECK("busy", 1'b0, mtpBusy)
        `CHECK("commits", v, volCnt)
        waitc(PROG + 50);
        `CHECK("nv writes", n, nvCnt)
    endtask : t_nv_cont

    task automatic t_nv_prog;
        word(5'h11, 16'habcd, 1'b1);
        frame_end();
        `CHECK("busy", 1'b1, mtpBusy)
        `CHECK("hv hold", 1'b1, hvHold)
        `CHECK("nv writes", n, nvCnt)
        word(ADDR_V0A, 16'h2468, 1'b1);
        frame_end();
        `CHECK("nack", 1'b0, nackSeen)
        `CHECK("data", 16'h2468, wrData)
        word(5'h12, 16'h1357, 1'b1);
        frame_end();
        `CHECK("nack", 1'b1, nackSeen)
        for (int i = 0; i < PROG; i++)
        begin
            @(posedge core_clk);
            if (nvCnt != n)
                break;
        end
        waitc(2);
        `CHECK("nv writes", n + 1, nvCnt)
        `CHECK("nv addr", 5'h11, wrAddr)
        `CHECK("nv data", 16'habcd, wrData)
        hvReq <= 1'b0;
        waitc(PROG);
        `CHECK("nv total", n + 1, nvCnt)
        `CHECK("hv released", 1'b0, hvHold)
    endtask : t_nv_prog

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (80000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end

    initial
    begin
        rst = 1'b1;
        cmdValid = 1'b0;
        cmdAddr = 5'h00;
        cmdData = 16'h0000;
        cmdLast = 1'b0;
        latchReq = 1'b0;
        hvReq = 1'b0;
        waitc(4);
        rst <= 1'b0;
        waitc(2);
        t_volatile();
        t_continuous();
        t_bad_addr();
        t_nv_no_hv();
        t_nv_cont();
        t_nv_prog();
        tally_and_finish();
    end
endmodule : tb

// File: src/dacwc_dev_end.sv
// DAC end of the two-wire write-command handler: frames, ACK/NACK,
// volatile commits, output latch and the programming cycle.
// Assumes bus lines and pin levels arrive from outside this clock.
// Functional notes
// - Commit volatile word on final data bit
// - Stop or Restart mid-word discards word
// - Master may Stop or Restart after ACK
// - Output register loads only while latch low
// - Without programming level, ACK but no change
// - Programming starts only after valid Stop
// - New Start accepted right after launching Stop
// - Master holds programming level until done
// - Volatile served, nonvolatile refused while busy
// - Nonvolatile word needs Stop, else NACK all
// - Nonvolatile write while busy is an error
// - Back-to-back volatile words in one frame
// - Master ends continuous writes with Stop/Restart
// - Volatile addresses 00,08,09,0A; 01 dual only
// - Continuous nonvolatile write NACKs, stores nothing
// - Any error NACKs everything until Start
// - Command bits 00 write, 11 read
// - Invalid address or command NACKed, sticks
`timescale 1ns/100ps
module dacwc_dev_end
    import dacwc_pkg::*;
#(
    parameter bit DUAL = 1'b1, // Two-channel variant
    parameter int PROG_CYC = PROG_CYCLES // Programming cycle in clocks
)
(
    input wire logic core_clk, // Core clock
    input wire logic rst, // Asynchronous reset, active high
    dacwc_bus_if.dev bus, // Two-wire bus, device side
    output logic [15:0] dacOut0, // Channel 0 output register
    output logic [15:0] dacOut1, // Channel 1 output register
    output logic wrStrobe, // One-cycle memory write pulse
    output logic wrNv, // Pulse belongs to nonvolatile memory
    output logic [4:0] wrAddr, // Written address
    output logic [15:0] wrData, // Written word
    output logic mtpBusy, // Programming cycle running
    output logic errFlag // Command error, held until Start
);
    logic [3:0] syn1;
    logic [3:0] syn2;
    logic [3:0] syn3;
    logic [3:0] filt;
    logic [1:0] prevLine;
    dacwc_dstate_t state;
    logic [3:0] bitCnt;
    logic [6:0] shiftReg;
    logic ackPend;
    logic sdaDrive;
    logic err;
    logic nvPend;
    logic [4:0] curAddr;
    logic curNv;
    logic [7:0] dataHi;
    logic [4:0] nvAddr;
    logic [15:0] nvData;
    logic [15:0] volReg0;
    logic [15:0] volReg1;
    logic [31:0] progCnt;

    wire [3:0] agree = ~(syn2 ^ syn3);
    wire sclF = filt[0];
    wire sdaF = filt[1];
    wire latLowF = filt[2];
    wire hvF = filt[3];

    wire sclRise = sclF & ~prevLine[0];
    wire sclFall = ~sclF & prevLine[0];
    wire startCond = sclF & prevLine[0] & prevLine[1] & ~sdaF;
    wire stopCond = sclF & prevLine[0] & ~prevLine[1] & sdaF;

    wire [7:0] rxByte = {shiftReg, sdaF};
    wire active = state != D_IDLE;
    wire byteDone = sclRise & active & (bitCnt == LAST_DATA_BIT);
    wire bitIn = sclRise & active & (bitCnt < LAST_DATA_BIT);
    wire [4:0] cmdAddr = rxByte[7:3];
    wire [1:0] cmdType = rxByte[2:1];
    wire addrMatch = (rxByte[7:1] == SLAVE_ADDR) & ~rxByte[0];
    wire isVol = (cmdAddr == ADDR_DAC0)
        | ((cmdAddr == ADDR_DAC1) & DUAL)
        | (cmdAddr == ADDR_V08)
        | (cmdAddr == ADDR_V09)
        | (cmdAddr == ADDR_V0A);
    wire isMtp = cmdAddr >= MTP_BASE;
    wire wrOk = isVol | (isMtp & ~mtpBusy);
    wire typeOk = (cmdType == CMD_READ)
        | ((cmdType == CMD_WRITE) & wrOk);
    wire cmdOk = ~nvPend & typeOk;
    wire inCmd = state == D_CMD;
    wire inData = (state == D_DHI) | (state == D_DLO);
    wire ackDec = ~err & ((state == D_CTRL) ? addrMatch
        : inCmd ? cmdOk : inData);
    wire cmdFault = byteDone & inCmd & ~cmdOk;
    wire lowDone = byteDone & (state == D_DLO) & ~err;
    wire volCommit = lowDone & ~curNv;
    wire nvCapture = lowDone & curNv;
    wire launch = stopCond & nvPend & ~err & hvF & ~mtpBusy;
    wire progDone = mtpBusy & hvF & (progCnt == 32'h1) & ~volCommit;
    dacwc_dstate_t next_state;

    assign next_state = (state == D_CTRL) ? (addrMatch ? D_CMD : D_SKIP)
        : inCmd ? ((cmdType == CMD_READ) ? D_SKIP : D_DHI)
        : (state == D_DHI) ? D_DLO
        : (state == D_DLO) ? D_CMD
        : D_SKIP;
    assign bus.devSdaOe = sdaDrive;
    assign bus.devSdaOut = 1'b0;
    assign errFlag = err;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            syn1 <= SYNC_RESET;
            syn2 <= SYNC_RESET;
            syn3 <= SYNC_RESET;
            filt <= SYNC_RESET;
            prevLine <= SYNC_RESET[1:0];
        end
        else
        begin
            syn1 <= {bus.hvHigh, bus.latLow, bus.sda, bus.scl};
            syn2 <= syn1;
            syn3 <= syn2;
            filt <= (agree & syn3) | (~agree & filt);
            prevLine <= filt[1:0];
        end
    end

    // Bit counter runs 0..7 for data, 8 and 9 around the ACK clock
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= D_IDLE;
            bitCnt <= 4'h0;
            ackPend <= 1'b0;
            sdaDrive <= 1'b0;
        end
        else if (startCond)
        begin
            state <= D_CTRL;
            bitCnt <= 4'h0;
            sdaDrive <= 1'b0;
        end
        else if (stopCond)
        begin
            state <= D_IDLE;
            bitCnt <= 4'h0;
            sdaDrive <= 1'b0;
        end
        else if (byteDone)
        begin
            state <= next_state;
            bitCnt <= ACK_SLOT;
            ackPend <= ackDec;
        end
        else if (bitIn)
        begin
            bitCnt <= bitCnt + 4'h1;
        end
        else if (sclFall & (bitCnt == ACK_SLOT))
        begin
            sdaDrive <= ackPend;
            bitCnt <= ACK_DRIVE;
        end
        else if (sclFall & (bitCnt == ACK_DRIVE))
        begin
            sdaDrive <= 1'b0;
            bitCnt <= 4'h0;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            shiftReg <= 7'h00;
        else if (bitIn)
            shiftReg <= rxByte[6:0];
    end

    // Error sticks until a Start; a Restart also drops a pending word
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            err <= 1'b0;
            nvPend <= 1'b0;
        end
        else if (startCond)
        begin
            err <= 1'b0;
            nvPend <= 1'b0;
        end
        else if (stopCond)
        begin
            nvPend <= 1'b0;
        end
        else
        begin
            if (cmdFault)
                err <= 1'b1;
            if (nvCapture)
                nvPend <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            curAddr <= 5'h00;
            curNv <= 1'b0;
            dataHi <= 8'h00;
            nvAddr <= 5'h00;
            nvData <= 16'h0000;
        end
        else if (byteDone)
        begin
            if (inCmd)
            begin
                curAddr <= cmdAddr;
                curNv <= isMtp;
            end
            if (state == D_DHI)
                dataHi <= rxByte;
            if (nvCapture)
            begin
                nvAddr <= curAddr;
                nvData <= {dataHi, rxByte};
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            volReg0 <= DAC_RESET;
            volReg1 <= DAC_RESET;
            dacOut0 <= DAC_RESET;
            dacOut1 <= DAC_RESET;
        end
        else
        begin
            if (volCommit & (curAddr == ADDR_DAC0))
                volReg0 <= {dataHi, rxByte};
            if (volCommit & (curAddr == ADDR_DAC1))
                volReg1 <= {dataHi, rxByte};
            if (latLowF)
            begin
                dacOut0 <= volReg0;
                dacOut1 <= volReg1;
            end
        end
    end

    // Losing the programming level aborts the cycle without a write
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mtpBusy <= 1'b0;
            progCnt <= 32'h0;
        end
        else if (launch)
        begin
            mtpBusy <= 1'b1;
            progCnt <= 32'(PROG_CYC);
        end
        else if (mtpBusy & ~hvF)
        begin
            mtpBusy <= 1'b0;
            progCnt <= 32'h0;
        end
        else if (mtpBusy & (progCnt > 32'h1))
        begin
            progCnt <= progCnt - 32'h1;
        end
        else if (progDone)
        begin
            mtpBusy <= 1'b0;
            progCnt <= 32'h0;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wrStrobe <= 1'b0;
            wrNv <= 1'b0;
            wrAddr <= 5'h00;
            wrData <= 16'h0000;
        end
        else
        begin
            wrStrobe <= volCommit | progDone;
            if (volCommit)
            begin
                wrNv <= 1'b0;
                wrAddr <= curAddr;
                wrData <= {dataHi, rxByte};
            end
            else if (progDone)
            begin
                wrNv <= 1'b1;
                wrAddr <= nvAddr;
                wrData <= nvData;
            end
        end
    end
endmodule : dacwc_dev_end

// File: src/dacwc_host_end.sv
// Host end: makes the serial clock, sends write frames word by word and
// drives the latch / high-voltage pin.
// Assumes the device never stretches the serial clock.
`timescale 1ns/100ps
module dacwc_host_end
    import dacwc_pkg::*;
#(
    parameter int HOLD_CYC = PROG_CYCLES + HV_MARGIN_CYC // Level hold
)
(
    input wire logic core_clk, // Core clock
    input wire logic rst, // Asynchronous reset, active high
    dacwc_bus_if.host bus, // Two-wire bus, host side
    input wire logic cmdValid, // A word is offered
    input wire logic [4:0] cmdAddr, // Target address of the word
    input wire logic [15:0] cmdData, // Word to write
    input wire logic cmdLast, // Close the frame with Stop after it
    input wire logic latchReq, // Pull the latch pin low unless the programming level is requested or held
    input wire logic hvReq, // Raise the pin to programming level
    output logic cmdReady, // Host takes the offered word
    output logic frameDone, // One-cycle pulse after the Stop
    output logic frameNack, // A NACK was seen in this frame
    output logic hvHold // Level held for a programming cycle
);
    logic sdaSyn1;
    logic sdaSyn2;
    logic sdaSyn3;
    logic sdaF;
    dacwc_hstate_t hstate;
    logic [2:0] qCnt;
    logic [1:0] q;
    logic [3:0] bitN;
    logic [1:0] byteIdx;
    logic [4:0] addr;
    logic [15:0] data;
    logic last;
    logic nvSeen;
    logic [31:0] hvCnt;
    logic sclOe;
    logic sdaOe;
    logic latPin;
    logic hvPin;

    wire take = cmdValid & cmdReady;
    wire tick = qCnt == 3'h0;
    wire ackSlot = bitN == ACK_SLOT;
    wire [7:0] byteVal = (byteIdx == 2'h0) ? {SLAVE_ADDR, 1'b0}
        : (byteIdx == 2'h1) ? {addr, CMD_WRITE, 1'b0}
        : (byteIdx == 2'h2) ? data[15:8]
        : data[7:0];
    wire sendLow = ~ackSlot & ~byteVal[~bitN[2:0]];
    wire stopNow = tick & (q == 2'h3) & (hstate == H_STOP);

    assign bus.hostSclOe = sclOe;
    assign bus.hostSclOut = 1'b0;
    assign bus.hostSdaOe = sdaOe;
    assign bus.hostSdaOut = 1'b0;
    assign bus.latLow = latPin;
    assign bus.hvHigh = hvPin;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sdaSyn1 <= 1'b1;
            sdaSyn2 <= 1'b1;
            sdaSyn3 <= 1'b1;
            sdaF <= 1'b1;
        end
        else
        begin
            sdaSyn1 <= bus.sda;
            sdaSyn2 <= sdaSyn1;
            sdaSyn3 <= sdaSyn2;
            if (sdaSyn2 == sdaSyn3)
                sdaF <= sdaSyn3;
        end
    end

    // Quarter-period divider, restarted whenever a word is taken
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            qCnt <= HOST_QUARTER - 3'h1;
            q <= 2'h0;
        end
        else if (take)
        begin
            qCnt <= HOST_QUARTER - 3'h1;
            q <= 2'h0;
        end
        else if (tick)
        begin
            qCnt <= HOST_QUARTER - 3'h1;
            q <= q + 2'h1;
        end
        else
        begin
            qCnt <= qCnt - 3'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            addr <= 5'h00;
            data <= 16'h0000;
            last <= 1'b1;
        end
        else if (take)
        begin
            addr <= cmdAddr;
            data <= cmdData;
            last <= cmdLast;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hstate <= H_IDLE;
            cmdReady <= 1'b1;
            bitN <= 4'h0;
            byteIdx <= 2'h0;
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
        end
        else if (take)
        begin
            cmdReady <= 1'b0;
            bitN <= 4'h0;
            byteIdx <= (hstate == H_WAIT) ? 2'h1 : 2'h0;
            hstate <= (hstate == H_WAIT) ? H_BYTE : H_START;
        end
        else if (tick)
        begin
            case (hstate)
                H_START:
                begin
                    if (q == 2'h1)
                        sdaOe <= 1'b1;
                    if (q == 2'h3)
                        sclOe <= 1'b1;
                    if (q == 2'h3)
                        hstate <= H_BYTE;
                end
                H_BYTE:
                begin
                    if (q == 2'h0)
                        sdaOe <= sendLow;
                    if (q == 2'h1)
                        sclOe <= 1'b0;
                    if (q == 2'h3)
                    begin
                        sclOe <= 1'b1;
                        bitN <= ackSlot ? 4'h0 : bitN + 4'h1;
                        if (ackSlot & (byteIdx != BYTE_LAST))
                            byteIdx <= byteIdx + 2'h1;
                        if (ackSlot & (byteIdx == BYTE_LAST))
                        begin
                            hstate <= last ? H_STOP : H_WAIT;
                            cmdReady <= ~last;
                        end
                    end
                end
                H_STOP:
                begin
                    if (q == 2'h0)
                        sdaOe <= 1'b1;
                    if (q == 2'h1)
                        sclOe <= 1'b0;
                    if (q == 2'h2)
                        sdaOe <= 1'b0;
                    if (q == 2'h3)
                    begin
                        hstate <= H_IDLE;
                        cmdReady <= 1'b1;
                    end
                end
                default:
                begin
                    hstate <= hstate;
                end
            endcase
        end
    end

    // Frame status and nonvolatile-word tracking
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            frameNack <= 1'b0;
            frameDone <= 1'b0;
            nvSeen <= 1'b0;
        end
        else
        begin
            frameDone <= stopNow;
            if (take & (hstate == H_IDLE))
                frameNack <= 1'b0;
            else if (tick & (q == 2'h3) & (hstate == H_BYTE) & ackSlot)
                frameNack <= frameNack | sdaF;
            if (take)
                nvSeen <= ((hstate == H_WAIT) & nvSeen)
                    | (cmdAddr >= MTP_BASE);
            else if (frameDone)
                nvSeen <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hvCnt <= 32'h0;
            hvHold <= 1'b0;
            latPin <= 1'b0;
            hvPin <= 1'b0;
        end
        else
        begin
            // Keep only a level that the user raised for this frame
            if (stopNow & nvSeen & hvPin)
            begin
                hvCnt <= 32'(HOLD_CYC);
                hvHold <= 1'b1;
            end
            else if (hvCnt != 32'h0)
            begin
                hvCnt <= hvCnt - 32'h1;
                hvHold <= hvCnt != 32'h1;
            end
            latPin <= latchReq & ~hvReq & ~hvHold;
            hvPin <= hvReq | hvHold;
        end
    end
endmodule : dacwc_host_end
